// ===== rtl/crs_pkg.sv
// Purpose: shared constants and types for the cpu core register set
// Assumes: 32-bit data path, sixteen general registers
// Notes:   status word bit positions and select codes are local choices
package crs_pkg;

  localparam int unsigned CRS_DATA_W  = 32;
  localparam int unsigned CRS_NUM_GPR = 16;
  localparam int unsigned CRS_IDX_W   = 4;

  typedef logic [CRS_DATA_W-1:0] crs_word_t;
  typedef logic [CRS_IDX_W-1:0]  crs_idx_t;

  localparam crs_idx_t  CRS_SP_IDX  = 4'h0;
  localparam int unsigned CRS_PSW_U_BIT = 17;
  localparam crs_word_t CRS_ZERO    = 32'h0000_0000;
  localparam crs_word_t CRS_PSW_RST = 32'h0000_0000;
  localparam crs_word_t CRS_PC_RST  = 32'h0000_0000;
  localparam crs_word_t CRS_SP_ALIGN_MASK = 32'h0000_0003;

  // selects which control register a control write or read reaches
  typedef enum logic [2:0] {
    CRS_CR_INT_SP,
    CRS_CR_USER_SP,
    CRS_CR_VEC_BASE,
    CRS_CR_PSW,
    CRS_CR_SAVED_CNT,
    CRS_CR_SAVED_STAT,
    CRS_CR_FAST_VEC,
    CRS_CR_PC
  } crs_cr_sel_t;

  // fast interrupt sequence
  typedef enum logic [1:0] {
    CRS_FI_IDLE,
    CRS_FI_SAVE,
    CRS_FI_BRANCH
  } crs_fi_state_t;

endpackage

// ===== rtl/crs_reg32.sv
// Purpose: one 32-bit register with load enable and reset value
// Assumes: single clock, asynchronous active high reset
// Notes:   reused for the saved counter, saved status, fast vector and vector base registers
`timescale 1ns/1ps
module crs_reg32 #(
  parameter crs_pkg::crs_word_t RST_VAL = crs_pkg::CRS_ZERO
) (
  input  wire logic               core_clk_i, // core clock
  input  wire logic               reset_i,    // async reset, high
  input  wire logic               load_i,     // load enable
  input  wire crs_pkg::crs_word_t d_i,        // next value
  output crs_pkg::crs_word_t      q_o         // stored value
);
  import crs_pkg::*;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q_o <= RST_VAL;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end

endmodule

// ===== rtl/crs_core_regs.sv
// Purpose: general and control register set of a 32-bit cpu core
// Assumes: pipeline and interrupt sequencer drive the ports synchronously
// Notes:   two gpr read ports, one gpr write port, one control port
//
// Behaviour
// - sixteen general registers, indices 0 to 15, data or address use.
// - general register 0 is the active one of the two stack pointers.
// - status word stack-select bit picks interrupt or user stack pointer.
// - vector table base register is the base for vector lookups.
// - program counter holds address of instruction being executed.
// - status word keeps result flags and cpu state, with stack select.
// - fast interrupt copies program counter into saved counter.
// - fast interrupt copies status word into saved status, same layout.
// - fast interrupt branches to fast vector register, no table fetch.
`timescale 1ns/1ps
module crs_core_regs (
  input  wire logic                 core_clk_i,     // core clock
  input  wire logic                 reset_i,        // async reset, high
  input  wire crs_pkg::crs_idx_t    rd_a_idx_i,     // read port a index
  input  wire crs_pkg::crs_idx_t    rd_b_idx_i,     // read port b index
  output crs_pkg::crs_word_t        rd_a_data_o,    // read port a data
  output crs_pkg::crs_word_t        rd_b_data_o,    // read port b data
  input  wire logic                 wr_en_i,        // gpr write strobe
  input  wire crs_pkg::crs_idx_t    wr_idx_i,       // gpr write index
  input  wire crs_pkg::crs_word_t   wr_data_i,      // gpr write data
  input  wire logic                 cr_wr_en_i,     // control write strobe
  input  wire crs_pkg::crs_cr_sel_t cr_sel_i,       // control select
  input  wire crs_pkg::crs_word_t   cr_wr_data_i,   // control write data
  output crs_pkg::crs_word_t        cr_rd_data_o,   // control read data
  input  wire logic                 pc_load_i,      // pipeline pc update
  input  wire crs_pkg::crs_word_t   pc_next_i,      // new pc value
  input  wire logic                 flags_load_i,   // result flag update
  input  wire crs_pkg::crs_word_t   flags_val_i,    // new flag values
  input  wire crs_pkg::crs_word_t   flags_mask_i,   // flag bits updated
  input  wire logic                 fast_irq_i,     // fast irq accept
  input  wire crs_pkg::crs_word_t   vec_offset_i,   // table vector offset
  output crs_pkg::crs_word_t        vec_addr_o,     // table entry address
  output crs_pkg::crs_word_t        program_counter_o,       // current pc
  output crs_pkg::crs_word_t        processor_status_word_o, // psw
  output crs_pkg::crs_word_t        active_stack_ptr_o,      // live sp
  output logic                      sp_misaligned_o, // sp not word aligned
  output logic                      fast_irq_busy_o  // fast irq in progress
);
  import crs_pkg::*;

  // ***********************************************************
  // general registers
  // ***********************************************************
  // index 0 has no cell here: it lives in the two stack pointers
  crs_word_t     gpr_q [1:CRS_NUM_GPR-1];
  crs_word_t     interrupt_stack_ptr_q;
  crs_word_t     user_stack_ptr_q;
  crs_word_t     psw_q;
  crs_word_t     pc_q;
  crs_word_t     vector_table_base_q;
  crs_word_t     fast_irq_saved_counter_q;
  crs_word_t     fast_irq_saved_status_q;
  crs_word_t     fast_irq_vector_q;
  crs_fi_state_t fi_state_q;
  logic          user_sel;
  logic          save_go;
  logic          branch_go;

  assign user_sel = psw_q[CRS_PSW_U_BIT];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 1; i < CRS_NUM_GPR; i++) begin
        gpr_q[i] <= CRS_ZERO;
      end
    end else if (wr_en_i && wr_idx_i != CRS_SP_IDX) begin
      gpr_q[wr_idx_i] <= wr_data_i;
    end
  end

  function automatic crs_word_t gpr_read(input crs_idx_t idx);
    if (idx == CRS_SP_IDX) begin
      gpr_read = active_stack_ptr_o;
    end else begin
      gpr_read = gpr_q[idx];
    end
  endfunction

  assign active_stack_ptr_o = user_sel ? user_stack_ptr_q
                                       : interrupt_stack_ptr_q;
  assign rd_a_data_o = gpr_read(rd_a_idx_i);
  assign rd_b_data_o = gpr_read(rd_b_idx_i);
  // alignment is advice to software; only reported, never enforced
  assign sp_misaligned_o =
    |(active_stack_ptr_o & CRS_SP_ALIGN_MASK);

  // ***********************************************************
  // stack pointers
  // ***********************************************************
  // a write to register 0 lands in whichever pointer is active
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      interrupt_stack_ptr_q <= CRS_ZERO;
    end else if (cr_wr_en_i && cr_sel_i == CRS_CR_INT_SP) begin
      interrupt_stack_ptr_q <= cr_wr_data_i;
    end else if (wr_en_i && wr_idx_i == CRS_SP_IDX && !user_sel) begin
      interrupt_stack_ptr_q <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      user_stack_ptr_q <= CRS_ZERO;
    end else if (cr_wr_en_i && cr_sel_i == CRS_CR_USER_SP) begin
      user_stack_ptr_q <= cr_wr_data_i;
    end else if (wr_en_i && wr_idx_i == CRS_SP_IDX && user_sel) begin
      user_stack_ptr_q <= wr_data_i;
    end
  end

  // ***********************************************************
  // fast interrupt sequence
  // ***********************************************************
  // save first, then branch: the saved counter never sees the vector
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fi_state_q <= CRS_FI_IDLE;
    end else begin
      case (fi_state_q)
        CRS_FI_IDLE: begin
          if (fast_irq_i) begin
            fi_state_q <= CRS_FI_SAVE;
          end
        end
        CRS_FI_SAVE: begin
          fi_state_q <= CRS_FI_BRANCH;
        end
        CRS_FI_BRANCH: begin
          fi_state_q <= CRS_FI_IDLE;
        end
        default: begin
          fi_state_q <= CRS_FI_IDLE;
        end
      endcase
    end
  end

  assign save_go         = (fi_state_q == CRS_FI_SAVE);
  assign branch_go       = (fi_state_q == CRS_FI_BRANCH);
  assign fast_irq_busy_o = (fi_state_q != CRS_FI_IDLE);

  crs_reg32 u_saved_pc (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (save_go || (cr_wr_en_i && cr_sel_i == CRS_CR_SAVED_CNT)),
    .d_i        (save_go ? pc_q : cr_wr_data_i),
    .q_o        (fast_irq_saved_counter_q)
  );

  crs_reg32 u_saved_psw (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (save_go || (cr_wr_en_i && cr_sel_i == CRS_CR_SAVED_STAT)),
    .d_i        (save_go ? psw_q : cr_wr_data_i),
    .q_o        (fast_irq_saved_status_q)
  );

  crs_reg32 u_fast_vec (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (cr_wr_en_i && cr_sel_i == CRS_CR_FAST_VEC),
    .d_i        (cr_wr_data_i),
    .q_o        (fast_irq_vector_q)
  );

  crs_reg32 u_vec_base (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .load_i     (cr_wr_en_i && cr_sel_i == CRS_CR_VEC_BASE),
    .d_i        (cr_wr_data_i),
    .q_o        (vector_table_base_q)
  );

  assign vec_addr_o =
    CRS_DATA_W'(vector_table_base_q + vec_offset_i);

  // ***********************************************************
  // program counter and status word
  // ***********************************************************
  // the branch outranks the pipeline: its update is stale by then
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_q <= CRS_PC_RST;
    end else if (branch_go) begin
      pc_q <= fast_irq_vector_q;
    end else if (!save_go && pc_load_i) begin
      pc_q <= pc_next_i;
    end else if (cr_wr_en_i && cr_sel_i == CRS_CR_PC) begin
      pc_q <= cr_wr_data_i;
    end
  end

  // status held steady while it is being saved
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      psw_q <= CRS_PSW_RST;
    end else if (save_go) begin
      psw_q <= psw_q;
    end else if (cr_wr_en_i && cr_sel_i == CRS_CR_PSW) begin
      psw_q <= cr_wr_data_i;
    end else if (flags_load_i) begin
      psw_q <= (psw_q & ~flags_mask_i)
             | (flags_val_i & flags_mask_i);
    end
  end

  assign program_counter_o       = pc_q;
  assign processor_status_word_o = psw_q;

  always_comb begin
    case (cr_sel_i)
      CRS_CR_INT_SP:     cr_rd_data_o = interrupt_stack_ptr_q;
      CRS_CR_USER_SP:    cr_rd_data_o = user_stack_ptr_q;
      CRS_CR_VEC_BASE:   cr_rd_data_o = vector_table_base_q;
      CRS_CR_PSW:        cr_rd_data_o = psw_q;
      CRS_CR_SAVED_CNT:  cr_rd_data_o = fast_irq_saved_counter_q;
      CRS_CR_SAVED_STAT: cr_rd_data_o = fast_irq_saved_status_q;
      CRS_CR_FAST_VEC:   cr_rd_data_o = fast_irq_vector_q;
      CRS_CR_PC:         cr_rd_data_o = pc_q;
      default:           cr_rd_data_o = CRS_ZERO;
    endcase
  end

endmodule

// ===== verif/crs_pipe_model.sv
// Purpose: pipeline side model that raises fast interrupt requests
// Assumes: one request per go pulse from the bench
// Notes:   holds a request until the sequencer is idle, so accepts
//          are never closer than the sequence length
`timescale 1ns/1ps
module crs_pipe_model (
  input  wire logic core_clk_i, // core clock
  input  wire logic reset_i,    // async reset, high
  input  wire logic go_i,       // bench asks for one request
  input  wire logic busy_i,     // sequence in progress
  output logic      fast_irq_o  // one-cycle request
);
  logic pend_q;
  logic fire;
  assign fire = pend_q & ~busy_i & ~fast_irq_o;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q     <= 1'b0;
      fast_irq_o <= 1'b0;
    end else begin
      pend_q     <= go_i | (pend_q & ~fire);
      fast_irq_o <= fire;
    end
  end
endmodule

// ===== verif/crs_core_regs_chk.sv
// Purpose: port-level assertions for the core register set
// Assumes: single clock domain, reset disables every check
// Notes:   internal saved registers are checked by the bench instead
`timescale 1ns/1ps
module crs_core_regs_chk
  import crs_pkg::*;
(
  input wire logic        core_clk_i,              // core clock
  input wire logic        reset_i,                 // async reset
  input wire crs_idx_t    rd_a_idx_i,              // read index a
  input wire crs_word_t   rd_a_data_o,             // read data a
  input wire logic        wr_en_i,                 // gpr write
  input wire crs_idx_t    wr_idx_i,                // gpr index
  input wire crs_word_t   wr_data_i,               // gpr data
  input wire logic        cr_wr_en_i,              // control write
  input wire crs_cr_sel_t cr_sel_i,                // control select
  input wire crs_word_t   cr_wr_data_i,            // control data
  input wire logic        pc_load_i,               // pc update
  input wire crs_word_t   pc_next_i,               // new pc
  input wire logic        flags_load_i,            // flag update
  input wire crs_word_t   flags_val_i,             // flag values
  input wire crs_word_t   flags_mask_i,            // flag mask
  input wire logic        fast_irq_i,              // fast irq
  input wire crs_word_t   vec_offset_i,            // vector offset
  input wire crs_word_t   vec_addr_o,              // vector address
  input wire crs_word_t   program_counter_o,       // pc
  input wire crs_word_t   processor_status_word_o, // psw
  input wire crs_word_t   active_stack_ptr_o,      // live sp
  input wire logic        sp_misaligned_o,         // sp flag
  input wire logic        fast_irq_busy_o          // sequence busy
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence fi_accept;
    fast_irq_i && !fast_irq_busy_o;
  endsequence
  sequence fi_run;
    fast_irq_busy_o [*2] ##1 !fast_irq_busy_o;
  endsequence
  a_gpr_write_read: assert property (
    (wr_en_i && wr_idx_i != CRS_SP_IDX) ##1 (rd_a_idx_i == $past(wr_idx_i))
    |-> rd_a_data_o == $past(wr_data_i)) else $error("gpr readback wrong");
  a_sp_alias: assert property (
    rd_a_idx_i == CRS_SP_IDX |-> rd_a_data_o == active_stack_ptr_o)
    else $error("register zero is not the stack pointer");
  a_sp_gpr_write: assert property (
    wr_en_i && wr_idx_i == CRS_SP_IDX && !cr_wr_en_i && !flags_load_i
    |=> active_stack_ptr_o == $past(wr_data_i))
    else $error("register zero write missed the stack pointer");
  a_int_sp_sel: assert property (
    cr_wr_en_i && cr_sel_i == CRS_CR_INT_SP && !flags_load_i
    && !processor_status_word_o[CRS_PSW_U_BIT]
    |=> active_stack_ptr_o == $past(cr_wr_data_i))
    else $error("interrupt stack pointer not selected");
  a_sp_align_flag: assert property (
    sp_misaligned_o == (active_stack_ptr_o[1:0] != 2'h0))
    else $error("alignment flag wrong");
  a_vec_base_add: assert property (
    cr_wr_en_i && cr_sel_i == CRS_CR_VEC_BASE
    |=> vec_addr_o == $past(cr_wr_data_i) + vec_offset_i)
    else $error("vector address not based on table base");
  a_pc_load_next: assert property (
    pc_load_i && !fast_irq_busy_o
    |=> program_counter_o == $past(pc_next_i)) else $error("pc not loaded");
  a_psw_flag_merge: assert property (
    flags_load_i && !fast_irq_busy_o && !(cr_wr_en_i && cr_sel_i == CRS_CR_PSW)
    |=> processor_status_word_o == (($past(processor_status_word_o)
    & ~$past(flags_mask_i)) | ($past(flags_val_i) & $past(flags_mask_i))))
    else $error("flag merge wrong");
  a_fi_pc_hold: assert property (
    fi_accept |=> ##1 $stable(program_counter_o))
    else $error("pc moved during save");
  a_fi_psw_hold: assert property (
    fi_accept |=> ##1 $stable(processor_status_word_o))
    else $error("psw moved during save");
  a_fi_seq_len: assert property (
    fi_accept |=> fi_run) else $error("fast sequence length wrong");
endmodule
bind crs_core_regs crs_core_regs_chk crs_core_regs_chk_inst (
  .core_clk_i, .reset_i, .rd_a_idx_i, .rd_a_data_o, .wr_en_i, .wr_idx_i,
  .wr_data_i, .cr_wr_en_i, .cr_sel_i, .cr_wr_data_i, .pc_load_i, .pc_next_i,
  .flags_load_i, .flags_val_i, .flags_mask_i, .fast_irq_i, .vec_offset_i,
  .vec_addr_o, .program_counter_o, .processor_status_word_o,
  .active_stack_ptr_o, .sp_misaligned_o, .fast_irq_busy_o);

// ===== verif/crs_core_regs_test.sv
// Purpose: self-checking bench for the core register set
// Assumes: comb outputs settle before the falling edge
// Notes:   drives at the rising edge, samples at the falling edge
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module crs_core_regs_test;
  import crs_pkg::*;
  logic        core_clk_i = 1'b0, reset_i = 1'b1, go_q = 1'b0;
  logic        wr_en_i = 1'b0, cr_wr_en_i = 1'b0, pc_load_i = 1'b0;
  logic        flags_load_i = 1'b0, fast_irq_i, sp_misaligned_o;
  logic        fast_irq_busy_o;
  crs_idx_t    rd_a_idx_i = '0, rd_b_idx_i = '0, wr_idx_i = '0;
  crs_cr_sel_t cr_sel_i = CRS_CR_INT_SP;
  crs_word_t   wr_data_i = '0, cr_wr_data_i = '0, pc_next_i = '0;
  crs_word_t   flags_val_i = '0, flags_mask_i = '0, vec_offset_i = '0;
  crs_word_t   rd_a_data_o, rd_b_data_o, cr_rd_data_o, vec_addr_o;
  crs_word_t   program_counter_o, processor_status_word_o;
  crs_word_t   active_stack_ptr_o;
  int          fail_count = 0, checked = 0;
  always #10 core_clk_i = ~core_clk_i;
  crs_core_regs crs_core_regs_inst (.core_clk_i, .reset_i, .rd_a_idx_i,
    .rd_b_idx_i, .rd_a_data_o, .rd_b_data_o, .wr_en_i, .wr_idx_i, .wr_data_i,
    .cr_wr_en_i, .cr_sel_i, .cr_wr_data_i, .cr_rd_data_o, .pc_load_i,
    .pc_next_i, .flags_load_i, .flags_val_i, .flags_mask_i, .fast_irq_i,
    .vec_offset_i, .vec_addr_o, .program_counter_o, .processor_status_word_o,
    .active_stack_ptr_o, .sp_misaligned_o, .fast_irq_busy_o);
  crs_pipe_model crs_pipe_model_inst (.core_clk_i, .reset_i, .go_i(go_q),
    .busy_i(fast_irq_busy_o), .fast_irq_o(fast_irq_i));
  task automatic stop_test;
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic gpr_wr(input crs_idx_t i, input crs_word_t d);
    @(posedge core_clk_i);
    wr_en_i <= 1'b1;
    wr_idx_i <= i;
    wr_data_i <= d;
    rd_a_idx_i <= i;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic cr_wr(input crs_cr_sel_t s, input crs_word_t d);
    @(posedge core_clk_i);
    cr_wr_en_i <= 1'b1;
    cr_sel_i <= s;
    cr_wr_data_i <= d;
    @(posedge core_clk_i);
    cr_wr_en_i <= 1'b0;
  endtask
  task automatic rd_chk(input crs_idx_t i, input crs_word_t e);
    @(posedge core_clk_i);
    rd_a_idx_i <= i;
    rd_b_idx_i <= i;
    @(negedge core_clk_i);
    `CHK(rd_a_data_o, e)
    `CHK(rd_b_data_o, e)
  endtask
  task automatic cr_chk(input crs_cr_sel_t s, input crs_word_t e);
    @(posedge core_clk_i);
    cr_sel_i <= s;
    @(negedge core_clk_i);
    `CHK(cr_rd_data_o, e)
  endtask
  // ****************************************************
  // test sequence; stack values stay word aligned unless probing the flag
  // ****************************************************
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(program_counter_o, CRS_PC_RST)
    `CHK(processor_status_word_o, CRS_PSW_RST)
    for (int i = 1; i < CRS_NUM_GPR; i++) begin
      gpr_wr(crs_idx_t'(i), 32'h5a5a_0000 + i);
    end
    for (int i = 1; i < CRS_NUM_GPR; i++) begin
      rd_chk(crs_idx_t'(i), 32'h5a5a_0000 + i);
    end
    cr_wr(CRS_CR_INT_SP, 32'h0000_0100);
    cr_wr(CRS_CR_USER_SP, 32'h0000_0200);
    rd_chk(CRS_SP_IDX, 32'h0000_0100);
    gpr_wr(CRS_SP_IDX, 32'h0000_0104);
    cr_chk(CRS_CR_INT_SP, 32'h0000_0104);
    cr_wr(CRS_CR_PSW, 32'h0002_0000);
    rd_chk(CRS_SP_IDX, 32'h0000_0200);
    gpr_wr(CRS_SP_IDX, 32'h0000_0202);
    cr_chk(CRS_CR_INT_SP, 32'h0000_0104);
    cr_chk(CRS_CR_USER_SP, 32'h0000_0202);
    `CHK(active_stack_ptr_o, 32'h0000_0202)
    `CHK(sp_misaligned_o, 1'b1)
    cr_wr(CRS_CR_VEC_BASE, 32'h0000_1000);
    vec_offset_i <= 32'h0000_0040;
    @(negedge core_clk_i);
    `CHK(vec_addr_o, 32'h0000_1040)
    @(posedge core_clk_i);
    pc_load_i <= 1'b1;
    pc_next_i <= 32'h0000_0400;
    flags_load_i <= 1'b1;
    flags_val_i <= 32'h0000_000f;
    flags_mask_i <= 32'h0000_0003;
    @(posedge core_clk_i);
    pc_load_i <= 1'b0;
    flags_load_i <= 1'b0;
    @(negedge core_clk_i);
    `CHK(program_counter_o, 32'h0000_0400)
    `CHK(processor_status_word_o, 32'h0002_0003)
    cr_wr(CRS_CR_FAST_VEC, 32'h0000_8000);
    @(posedge core_clk_i);
    go_q <= 1'b1;
    @(posedge core_clk_i);
    go_q <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CHK(program_counter_o, 32'h0000_8000)
    `CHK(fast_irq_busy_o, 1'b0)
    cr_chk(CRS_CR_SAVED_CNT, 32'h0000_0400);
    cr_chk(CRS_CR_SAVED_STAT, 32'h0002_0003);
    cr_chk(CRS_CR_FAST_VEC, 32'h0000_8000);
    cr_chk(CRS_CR_VEC_BASE, 32'h0000_1000);
    cr_chk(CRS_CR_PC, 32'h0000_8000);
    cr_wr(CRS_CR_PC, 32'h0000_0500);
    @(negedge core_clk_i);
    `CHK(program_counter_o, 32'h0000_0500)
    stop_test();
  end
  initial begin
    #100us;
    fail_count++;
    stop_test();
  end
endmodule
